//--- dahp_consts.vh
`ifndef DAHP_CONSTS_VH
`define DAHP_CONSTS_VH
// Data word width, pipeline depth, FIFO depth and its address width
`define DAHP_DATA_W 10
`define DAHP_PIPE_LAT 7
`define DAHP_FIFO_DEPTH 16
`define DAHP_FIFO_AW 4
// Register address of the two control registers
`define DAHP_ADDR_CR0 2'h0
`define DAHP_ADDR_CR1 2'h1
// Control register 0 fields
`define DAHP_CR0_EXTREF 0
`define DAHP_CR0_SINGLE 1
`define DAHP_CR0_CHSEL_LO 2
`define DAHP_CR0_CHSEL_HI 3
`define DAHP_CR0_DIFF 4
`define DAHP_CR0_FIFORST 9
// Control register 1 fields
`define DAHP_CR1_RWSPLIT 0
`define DAHP_CR1_DAVHIGH 1
`define DAHP_CR1_DAVPULSE 2
`define DAHP_CR1_TL_LO 3
`define DAHP_CR1_TL_HI 6
// Reset values
`define DAHP_CR0_RST 10'h000
`define DAHP_CR1_RST 10'h008
// Internal oscillator period in ns and its cycle count at 200 MHz
`define DAHP_CLK_NS 5
`define DAHP_OSC_NS 125
`define DAHP_OSC_CYC ((`DAHP_OSC_NS + `DAHP_CLK_NS - 1) / `DAHP_CLK_NS)
`endif

//--- dahp_sync.v
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for a bundle of pin inputs
module dahp_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] asyncIn,
    output reg [W-1:0] syncOut
);
    reg [W-1:0] meta_q;

    // First stage read only by the second
    always @(posedge clk) begin
        if (rst) begin
            meta_q <= {W{1'b0}};
            syncOut <= {W{1'b0}};
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // dahp_sync
`default_nettype wire

//--- dahp_pipe.v
`timescale 1ns/1ps
`default_nettype none
`include "dahp_consts.vh"
// Seven-stage conversion pipeline model: a sample appears LAT steps later
module dahp_pipe #(
    parameter W = `DAHP_DATA_W,
    parameter LAT = `DAHP_PIPE_LAT
) (
    input wire clk,
    input wire rst,
    input wire flush,
    input wire step,
    input wire validIn,
    input wire [W-1:0] sampleIn,
    output wire [W-1:0] sampleOut,
    output wire sampleValid
);
    reg [W-1:0] stage_q [0:LAT-1];
    reg [LAT-1:0] valid_q;
    genvar i;

    // One stage per step; flush empties the in-flight samples
    generate
        for (i = 0; i < LAT; i = i + 1) begin : gStage
            always @(posedge clk) begin
                if (rst || flush) begin
                    stage_q[i] <= {W{1'b0}};
                    valid_q[i] <= 1'b0;
                end else if (step) begin
                    stage_q[i] <= (i == 0) ? sampleIn : stage_q[(i == 0) ? 0 : i-1];
                    valid_q[i] <= (i == 0) ? validIn : valid_q[(i == 0) ? 0 : i-1];
                end
            end
        end
    endgenerate

    assign sampleOut = stage_q[LAT-1];
    assign sampleValid = valid_q[LAT-1] & step;
endmodule // dahp_pipe
`default_nettype wire

//--- dahp_host_port.v
// Operation
// RULE_01: Ten-bit tristate data bus, bit 0 LSB
// RULE_02: Address lines pick control register 0 or 1
// RULE_03: Overflow flag rises on FIFO overflow, sticks
// RULE_04: Only reset or FIFO reset clears overflow
// RULE_05: Hardware reset loads control register defaults
// RULE_06: Write input is direction or write strobe
// RULE_07: Read strobe honoured only in split mode
// RULE_08: Register 0 selects internal or external reference
// RULE_09: Both selected inputs sampled at once; continuous two-channel mode converts B from the next falling edge after its A
// RULE_10: Channel select and single-ended or differential
// RULE_11: Seven-sample pipeline latency for conversions
// RULE_12: First data-available after seven plus trigger level
// RULE_13: Single mode: trigger starts, oscillator times conversion
// RULE_14: Continuous mode: convert on clock falling edge
// RULE_15: Register 0 bit 1 selects single mode
// RULE_16: Continuous mode: FIFO write on clock rise
// RULE_17: Data-available polarity and level or pulse
// RULE_18: Respond only while both chip selects active
// RULE_19: Drive data bus only during selected read
`timescale 1ns/1ps
`default_nettype none
`include "dahp_consts.vh"
module dahp_host_port #(
    parameter W = `DAHP_DATA_W,
    parameter DEPTH = `DAHP_FIFO_DEPTH,
    parameter AW = `DAHP_FIFO_AW,
    parameter OSC_CYC = `DAHP_OSC_CYC
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] parallelDataLinesIn,
    output reg [W-1:0] parallelDataLinesOut,
    output reg parallelDataLinesOe,
    input wire regAddrBit0,
    input wire regAddrBit1,
    input wire selectLowActiveN,
    input wire selectHighActive,
    input wire writeStrobe,
    input wire readStrobeN,
    input wire singleConversionTriggerN,
    input wire [W-1:0] sampleChanA,
    input wire [W-1:0] sampleChanB,
    output reg fifoOverflowFlag,
    output reg sampleReadyFlag,
    output reg extRefSelect,
    output reg [1:0] chanSelect,
    output reg diffMode
);
    // Pin inputs pass two flip-flops first
    wire [W-1:0] dInS;
    wire [7:0] ctlS;
    wire ra0S, ra1S, csLoS, csHiS, wrS, rdS, convActS, spare0;
    dahp_sync #(.W(W)) uSyncD (
        .clk(clk),
        .rst(rst),
        .asyncIn(parallelDataLinesIn),
        .syncOut(dInS)
    );
    dahp_sync #(.W(8)) uSyncC (
        .clk(clk),
        .rst(rst),
        // Trigger enters inverted so the stage reset value equals its idle high;
        // otherwise the first edges after reset would look like a clock rise
        .asyncIn({1'b0, ~singleConversionTriggerN, readStrobeN, writeStrobe,
            selectHighActive, selectLowActiveN, regAddrBit1, regAddrBit0}),
        .syncOut(ctlS)
    );
    assign {spare0, convActS, rdS, wrS, csHiS, csLoS, ra1S, ra0S} = ctlS;
    // Back to pin polarity for the edge detectors
    wire convS = ~convActS;

    reg [W-1:0] cr0_q, cr1_q;
    reg wrPrev_q, convPrev_q, rdPrev_q;
    wire sel = ~csLoS & csHiS; // RULE_18
    wire split = cr1_q[`DAHP_CR1_RWSPLIT];
    wire singleMode = cr0_q[`DAHP_CR0_SINGLE]; // RULE_15
    // Split: write on low strobe, read on low read strobe (RULE_06)
    wire wrActive = split ? ~wrS : ~wrS;
    wire rdActive = split ? ~rdS : wrS; // RULE_07
    wire wrStart = sel & wrActive & ~wrPrev_q;
    wire rdEnd = ~(sel & rdActive) & rdPrev_q;
    wire [1:0] regAddr = {ra1S, ra0S}; // RULE_02
    wire fifoRst = cr0_q[`DAHP_CR0_FIFORST];

    // Edge history of strobes and conversion clock
    always @(posedge clk) begin
        if (rst) begin
            wrPrev_q <= 1'b0;
            rdPrev_q <= 1'b0;
            convPrev_q <= 1'b1;
        end else begin
            wrPrev_q <= sel & wrActive;
            rdPrev_q <= sel & rdActive;
            convPrev_q <= convS;
        end
    end

    // Control register writes; FIFO reset bit self-clears after one cycle
    always @(posedge clk) begin
        if (rst) begin
            cr0_q <= `DAHP_CR0_RST; // RULE_05
            cr1_q <= `DAHP_CR1_RST; // RULE_05
        end else begin
            if (fifoRst) begin
                cr0_q[`DAHP_CR0_FIFORST] <= 1'b0;
            end
            if (wrStart && regAddr == `DAHP_ADDR_CR0) begin
                cr0_q <= dInS; // RULE_02
            end else if (wrStart && regAddr == `DAHP_ADDR_CR1) begin
                cr1_q <= dInS; // RULE_02
            end
        end
    end

    // Configuration outputs registered from the control fields
    always @(posedge clk) begin
        if (rst) begin
            extRefSelect <= 1'b0;
            chanSelect <= 2'h0;
            diffMode <= 1'b0;
        end else begin
            extRefSelect <= cr0_q[`DAHP_CR0_EXTREF]; // RULE_08
            chanSelect <= cr0_q[`DAHP_CR0_CHSEL_HI:`DAHP_CR0_CHSEL_LO]; // RULE_10
            diffMode <= cr0_q[`DAHP_CR0_DIFF]; // RULE_10
        end
    end

    // Conversion sequencing
    localparam S_IDLE = 2'h0;
    localparam S_CONVA = 2'h1;
    localparam S_CONVB = 2'h2;
    // Drain pushes the last real sample out of the pipeline on oscillator ticks;
    // without it a lone single conversion would never reach the FIFO
    localparam S_DRAIN = 2'h3;
    localparam integer DRAIN_LAST = `DAHP_PIPE_LAT - 1;
    reg [1:0] state_q;
    reg [2:0] drainCnt_q;
    reg [7:0] oscCnt_q;
    reg [W-1:0] holdA_q, holdB_q;
    wire convFall = convPrev_q & ~convS;
    wire convRise = ~convPrev_q & convS;
    // Integer first so the cut to the counter width is deliberate
    localparam integer OSC_LAST = OSC_CYC - 1;
    wire oscTick = (oscCnt_q == OSC_LAST[7:0]);
    // Differential mode is one channel; otherwise select bits count
    wire twoChan = ~diffMode & chanSelect[0] & chanSelect[1];
    wire chanBOnly = ~diffMode & chanSelect[1] & ~chanSelect[0];

    // Hold both inputs together on the start edge
    always @(posedge clk) begin
        if (rst) begin
            holdA_q <= {W{1'b0}};
            holdB_q <= {W{1'b0}};
        end else if (convFall) begin
            holdA_q <= sampleChanA; // RULE_09
            holdB_q <= sampleChanB; // RULE_09
        end
    end

    // Single mode steps on the internal oscillator, continuous on rise
    always @(posedge clk) begin
        if (rst || fifoRst) begin
            state_q <= S_IDLE;
            oscCnt_q <= 8'h00;
            drainCnt_q <= 3'h0;
        end else begin
            oscCnt_q <= (state_q == S_IDLE || oscTick) ? 8'h00 : oscCnt_q + 8'h01;
            case (state_q)
                S_IDLE: begin
                    if (singleMode && convFall) begin
                        state_q <= S_CONVA; // RULE_13
                    end
                end
                S_CONVA: begin
                    if (oscTick) begin
                        state_q <= twoChan ? S_CONVB : S_DRAIN; // RULE_13
                    end
                end
                S_CONVB: begin
                    if (oscTick) begin
                        state_q <= S_DRAIN;
                    end
                end
                // Triggers are ignored here; the host must space its starts
                S_DRAIN: begin
                    if (oscTick) begin
                        if (drainCnt_q == DRAIN_LAST[2:0]) begin
                            drainCnt_q <= 3'h0;
                            state_q <= S_IDLE; // RULE_11
                        end else begin
                            drainCnt_q <= drainCnt_q + 3'h1;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Pipeline step and word chosen for it
    reg contPhase_q;
    wire contStep = ~singleMode & convRise; // RULE_14 RULE_16
    wire singleStep = singleMode & oscTick & (state_q != S_IDLE);
    wire step = contStep | singleStep;
    // Drain steps carry no sample, so they must not mark a valid entry
    wire pipeValidIn = ~(singleMode & (state_q == S_DRAIN));
    wire useB = singleMode ? (state_q == S_CONVB || chanBOnly)
                           : (twoChan ? contPhase_q : chanBOnly);
    wire [W-1:0] pipeIn = useB ? holdB_q : holdA_q;
    wire [W-1:0] pipeOut;
    wire pipeValid;

    // Two-channel continuous mode alternates A then B
    always @(posedge clk) begin
        if (rst || fifoRst) begin
            contPhase_q <= 1'b0;
        end else if (contStep) begin
            contPhase_q <= twoChan & ~contPhase_q;
        end
    end

    dahp_pipe #(.W(W), .LAT(`DAHP_PIPE_LAT)) uPipe (
        .clk(clk),
        .rst(rst),
        .flush(fifoRst),
        .step(step),
        .validIn(pipeValidIn),
        .sampleIn(pipeIn),
        .sampleOut(pipeOut),
        .sampleValid(pipeValid)
    ); // RULE_11 RULE_12

    // Circular FIFO; a write into a full FIFO overflows and is dropped
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_q, rdPtr_q;
    reg [AW:0] count_q;
    wire full = (count_q == DEPTH);
    wire empty = (count_q == 0);
    wire push = pipeValid & ~full;
    wire pop = rdEnd & ~empty;
    always @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= pipeOut;
        end
    end
    always @(posedge clk) begin
        if (rst || fifoRst) begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    // Sticky overflow; only reset paths clear it
    // A drop in the same cycle as a FIFO reset still sets it, so no loss goes unseen
    always @(posedge clk) begin
        if (rst) begin
            fifoOverflowFlag <= 1'b0; // RULE_04
        end else if (pipeValid && full) begin
            fifoOverflowFlag <= 1'b1; // RULE_03
        end else if (fifoRst) begin
            fifoOverflowFlag <= 1'b0; // RULE_04
        end
    end

    // Data-available: level at trigger level, or one-cycle pulse on reaching it
    wire [3:0] trigLvl = cr1_q[`DAHP_CR1_TL_HI:`DAHP_CR1_TL_LO];
    wire atLevel = (count_q >= {1'b0, trigLvl}) & (trigLvl != 4'h0);
    reg atLevelPrev_q;
    wire davRaw = cr1_q[`DAHP_CR1_DAVPULSE] ? (atLevel & ~atLevelPrev_q) : atLevel;
    always @(posedge clk) begin
        if (rst) begin
            atLevelPrev_q <= 1'b0;
            sampleReadyFlag <= 1'b0;
        end else begin
            atLevelPrev_q <= atLevel;
            sampleReadyFlag <= cr1_q[`DAHP_CR1_DAVHIGH] ? davRaw : ~davRaw; // RULE_17
        end
    end

    // Read data and bus drive; drive only in a selected read
    always @(posedge clk) begin
        if (rst) begin
            parallelDataLinesOut <= {W{1'b0}};
            parallelDataLinesOe <= 1'b0;
        end else begin
            parallelDataLinesOut <= empty ? {W{1'b0}} : mem[rdPtr_q]; // RULE_01
            parallelDataLinesOe <= sel & rdActive; // RULE_19
        end
    end
endmodule // dahp_host_port
`default_nettype wire

//--- dahp_host_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level timing relations of the host port
module dahp_host_port_sva #(
    parameter W = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] parallelDataLinesOut,
    input wire logic parallelDataLinesOe,
    input wire logic selectLowActiveN,
    input wire logic selectHighActive,
    input wire logic writeStrobe,
    input wire logic singleConversionTriggerN,
    input wire logic fifoOverflowFlag,
    input wire logic extRefSelect,
    input wire logic [1:0] chanSelect,
    input wire logic diffMode
);
    logic [3:0] selCnt;
    logic [3:0] wrCnt;
    logic [3:0] trigCnt;
    logic trigPrev;
    wire sel = !selectLowActiveN && selectHighActive;
    // Cycles since select, write and trigger edge; saturate so idle spans never wrap
    always @(posedge clk) begin
        trigPrev <= singleConversionTriggerN;
        if (rst) begin
            selCnt <= 4'hF;
            wrCnt <= 4'hF;
            trigCnt <= 4'hF;
        end else begin
            selCnt <= sel ? 4'h0 : selCnt + {3'h0, selCnt != 4'hF};
            wrCnt <= (sel && !writeStrobe) ? 4'h0 : wrCnt + {3'h0, wrCnt != 4'hF};
            trigCnt <= (singleConversionTriggerN != trigPrev) ? 4'h0
                : trigCnt + {3'h0, trigCnt != 4'hF};
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    oe_needs_sel_a: assert property (parallelDataLinesOe |-> selCnt <= 4'h5)
        else $error("bus driven while unselected");
    oe_read_dir_a: assert property ($rose(parallelDataLinesOe) |-> wrCnt >= 4'h2)
        else $error("bus driven during a write");
    oe_holds_a: assert property ($rose(parallelDataLinesOe) |=> parallelDataLinesOe)
        else $error("read drive dropped early");
    data_steady_a: assert property (parallelDataLinesOe && $past(parallelDataLinesOe)
        |-> $stable(parallelDataLinesOut)) else $error("read word changed mid read");
    ovf_set_cause_a: assert property ($rose(fifoOverflowFlag) |-> trigCnt <= 4'hC)
        else $error("overflow without conversion");
    ovf_clear_cause_a: assert property ($fell(fifoOverflowFlag) |-> wrCnt <= 4'h8)
        else $error("overflow cleared without reset");
    cfg_change_cause_a: assert property (
        !$stable({extRefSelect, chanSelect, diffMode}) |-> wrCnt <= 4'h6)
        else $error("config changed without write");
    reset_clear_a: assert property ($fell(rst) |-> !(parallelDataLinesOe || fifoOverflowFlag
        || extRefSelect || diffMode || chanSelect != 2'h0)) else $error("reset state wrong");
endmodule // dahp_host_port_sva
bind dahp_host_port dahp_host_port_sva #(.W(W)) u_sva (
    .clk(clk), .rst(rst), .parallelDataLinesOut(parallelDataLinesOut),
    .parallelDataLinesOe(parallelDataLinesOe), .selectLowActiveN(selectLowActiveN),
    .selectHighActive(selectHighActive), .writeStrobe(writeStrobe),
    .singleConversionTriggerN(singleConversionTriggerN), .fifoOverflowFlag(fifoOverflowFlag),
    .extRefSelect(extRefSelect), .chanSelect(chanSelect), .diffMode(diffMode)
);
`default_nettype wire

//--- dahp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host processor on the parallel bus; pins change just after a falling edge
module dahp_host_model (
    input wire logic clk,
    input wire logic [9:0] busOut,
    input wire logic busOe,
    output logic [9:0] busLevel,
    output logic addr0,
    output logic addr1,
    output logic selN,
    output logic selH,
    output logic wrStrobe,
    output logic rdStrobeN
);
    logic [9:0] hostData = 10'h000;
    logic [9:0] lastLevel = 10'h000;
    logic hostDrive = 1'b0;
    // Idle pins: unselected, no strobes
    initial begin
        {addr1, addr0, selN, selH, wrStrobe, rdStrobeN} = 6'b001011;
    end
    // Released bus shows the inverse of its last level, not a kind stale copy
    assign busLevel = busOe ? busOut : (hostDrive ? hostData : ~lastLevel);
    always @(posedge clk) begin
        if (busOe || hostDrive) begin
            lastLevel <= busLevel;
        end
    end
    // Held four cycles so the write survives the input synchronisers
    task automatic writeReg(input logic [1:0] addr, input logic [9:0] data, input logic doSel);
        @(negedge clk);
        {addr1, addr0} = addr;
        hostData = data;
        hostDrive = 1'b1;
        wrStrobe = 1'b0;
        selN = !doSel;
        selH = doSel;
        repeat (4) @(negedge clk);
        {selN, selH, wrStrobe, hostDrive} = 4'hA;
        repeat (4) @(negedge clk);
    endtask
    // Read held until the drive is seen or ten cycles pass, then two more cycles
    task automatic readWord(input logic useRd, output logic got);
        int n;
        got = 1'b0;
        @(negedge clk);
        rdStrobeN = !useRd;
        selN = 1'b0;
        selH = 1'b1;
        for (n = 0; n < 10 && !got; n++) begin
            @(posedge clk);
            got = busOe;
        end
        repeat (2) @(negedge clk);
        {selN, selH, rdStrobeN} = 3'h5;
        repeat (4) @(negedge clk);
    endtask
endmodule // dahp_host_model
`default_nettype wire

//--- dahp_host_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dahp_host_port_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic trigN = 1'b1;
    logic [9:0] sampleA = 10'h000;
    logic [9:0] sampleB = 10'h000;
    logic [9:0] busLevel, busOut, cfg;
    logic busOe, addr0, addr1, selN, selH, wrStb, rdStbN, ovf, dav, extRef, diff, got;
    logic oePrev = 1'b0;
    logic [1:0] chanSel;
    logic [9:0] expQ[$];
    logic [9:0] samples[$];
    int err_count = 0;
    int total_checks = 0;
    int seed = 86623;
    int n;
    dahp_host_port dut (
        .clk(clk), .rst(rst), .parallelDataLinesIn(busLevel), .parallelDataLinesOut(busOut),
        .parallelDataLinesOe(busOe), .regAddrBit0(addr0), .regAddrBit1(addr1),
        .selectLowActiveN(selN), .selectHighActive(selH), .writeStrobe(wrStb),
        .readStrobeN(rdStbN), .singleConversionTriggerN(trigN), .sampleChanA(sampleA),
        .sampleChanB(sampleB), .fifoOverflowFlag(ovf), .sampleReadyFlag(dav),
        .extRefSelect(extRef), .chanSelect(chanSel), .diffMode(diff)
    );
    dahp_host_model host (
        .clk(clk), .busOut(busOut), .busOe(busOe), .busLevel(busLevel), .addr0(addr0),
        .addr1(addr1), .selN(selN), .selH(selH), .wrStrobe(wrStb), .rdStrobeN(rdStbN)
    );
    // 200 MHz
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Conversion clock; each level lasts several cycles to pass the synchroniser
    task automatic conv(input int cnt, input int lowCyc);
        repeat (cnt) begin
            @(negedge clk);
            sampleA = 10'($random(seed));
            sampleB = 10'($random(seed));
            samples.push_back(sampleA);
            @(negedge clk);
            trigN = 1'b0;
            repeat (lowCyc) @(negedge clk);
            trigN = 1'b1;
            repeat (2) @(negedge clk);
        end
    endtask
    // Note the oldest stored sample, then read it
    task automatic readSample(input logic useRd);
        expQ.push_back(samples.pop_front());
        host.readWord(useRd, got);
        check("read answered", got, 1'b1);
    endtask
    // Each new read shows one word; compare with the oldest note
    always @(negedge clk) begin
        oePrev <= busOe;
        if (busOe && !oePrev) begin
            if (expQ.size() == 0) begin
                check("unasked read", 10'h001, 10'h000);
            end else begin
                check("fifo word", busOut, expQ.pop_front());
            end
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check("reset state", {busOe, ovf, extRef, chanSel, diff, dav}, 10'h001);
        cfg = (10'($random(seed)) & 10'h011) | 10'h004;
        host.writeReg(2'h0, cfg, 1'b1);
        check("config", {extRef, chanSel, diff}, {cfg[0], cfg[3:2], cfg[4]});
        host.writeReg(2'h2, ~cfg, 1'b1);
        host.writeReg(2'h3, ~cfg, 1'b1);
        host.writeReg(2'h0, ~cfg, 1'b0);
        check("config kept", {extRef, chanSel, diff}, {cfg[0], cfg[3:2], cfg[4]});
        host.writeReg(2'h0, 10'h204, 1'b1);
        samples.delete();
        conv(6, 3);
        check("ready early", dav, 1'b1);
        conv(4, 3);
        check("ready", dav, 1'b0);
        repeat (3) readSample(1'b0);
        host.writeReg(2'h0, 10'h204, 1'b1);
        samples.delete();
        conv(25, 3);
        check("overflow set", ovf, 1'b1);
        readSample(1'b0);
        host.writeReg(2'h1, 10'h008, 1'b1);
        check("overflow kept", ovf, 1'b1);
        host.writeReg(2'h0, 10'h204, 1'b1);
        samples.delete();
        check("overflow cleared", ovf, 1'b0);
        host.writeReg(2'h1, 10'h00B, 1'b1);
        check("ready high idle", dav, 1'b0);
        host.readWord(1'b0, got);
        check("split no strobe", got, 1'b0);
        conv(9, 3);
        check("ready high", dav, 1'b1);
        readSample(1'b1);
        host.writeReg(2'h0, 10'h206, 1'b1);
        samples.delete();
        conv(1, 40);
        for (n = 0; n < 1000 && dav !== 1'b1; n++) begin
            @(negedge clk);
        end
        check("single ready", dav, 1'b1);
        readSample(1'b1);
        complete_run();
    end
    // Hang guard, well beyond the several hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule // dahp_host_port_tb_top
`default_nettype wire
